// ---- rtl/psf_crc16.sv ----
`timescale 1ns/1ns
`default_nettype none

module psf_crc16 (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rstn_i,
	// Engine side
	psf_crc_if.calc   crc
);

	logic [15:0] crc_q;
	logic [15:0] crc_d;

	always_comb begin
		crc_d = crc_q;
		if (crc.clr) begin
			crc_d = psf_pkg::CRC_INIT;
		end else if (crc.en) begin
			crc_d = crc_q ^ {8'h00, crc.data};
			for (int i = 0; i < 8; i++) begin
				crc_d = crc_d[0] ? ((crc_d >> 1) ^ psf_pkg::CRC_POLY) : (crc_d >> 1);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			crc_q <= psf_pkg::CRC_INIT;
		end else begin
			crc_q <= crc_d;
		end
	end

	assign crc.crc = crc_q;

endmodule

`default_nettype wire

// ---- rtl/psf_crc_if.sv ----
`timescale 1ns/1ns
`default_nettype none

interface psf_crc_if;
	logic        clr;
	logic        en;
	logic [7:0]  data;
	logic [15:0] crc;

	modport eng  (output clr, output en, output data, input crc);
	modport calc (input clr, input en, input data, output crc);
endinterface

`default_nettype wire

// ---- rtl/psf_framer.sv ----
// Behaviour
// - Packet mode keeps the transmit payload and the received length, payload and check bytes in on-chip buffers.
// - Streaming mode moves payload one byte at a time through the port.
// - Transmit sends four preamble bytes, then delimiter, then length byte.
// - Payload is at most 125 bytes; longer frames are refused.
// - A two-byte check sequence is computed and sent after the payload.
// - Receive finds preamble, delimiter, length and stores payload and check bytes.
// - Receive recomputes the check sequence and reports pass or fail.
// - Link quality is measured for 64 us after the delimiter and kept.
// - Channel assessment integrates energy over a fixed interval.
// - Packet mode raises the interrupt once per complete received frame.
// - Streaming receive raises the interrupt for every received payload and check byte.
// - Packet mode raises the interrupt when the whole frame is sent.
// - Streaming transmit raises the interrupt whenever the next byte is wanted.
// - Host talks over a four-wire serial port plus an interrupt line.
// - Exactly one of 16 channels is selected at any time.
`timescale 1ns/1ns
`default_nettype none

module psf_framer #(
	parameter int LQI_CYC = psf_pkg::LQI_CYC,
	parameter int CCA_CYC = psf_pkg::CCA_CYC,
	parameter int CCA_THR = psf_pkg::CCA_THR
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	// Host serial port and interrupt
	input  wire logic        spi_sck_i,
	input  wire logic        spi_cs_n_i,
	input  wire logic        spi_mosi_i,
	output logic             spi_miso_o,
	output logic             spi_miso_oe_o,
	output logic             irq_o,
	// Modem transmit byte stream
	output logic [7:0]       tx_data_o,
	output logic             tx_valid_o,
	input  wire logic        tx_ready_i,
	// Modem receive byte stream
	input  wire logic [7:0]  rx_data_i,
	input  wire logic        rx_valid_i,
	input  wire logic [7:0]  rx_energy_i,
	// Radio setup
	output logic [3:0]       chan_o
);
	import psf_pkg::*;

	typedef enum logic [7:0] {
		T_IDLE = 8'h01, T_PRE = 8'h02, T_SFD = 8'h04, T_LEN = 8'h08,
		T_FETCH = 8'h10, T_PAY = 8'h20, T_FCS0 = 8'h40, T_FCS1 = 8'h80
	} psf_tx_e;
	typedef enum logic [3:0] {
		R_HUNT = 4'h1, R_LEN = 4'h2, R_DATA = 4'h4, R_CHK = 4'h8
	} psf_rx_e;

	localparam logic [ACC_W-1:0] CCA_LIM = ACC_W'(CCA_THR * CCA_CYC);

	psf_crc_if txc ();
	psf_crc_if rxc ();
	psf_crc16 u_txcrc (.clk_i(clk_i), .rstn_i(rstn_i), .crc(txc));
	psf_crc16 u_rxcrc (.clk_i(clk_i), .rstn_i(rstn_i), .crc(rxc));

	logic [7:0] tx_mem [BUF_DEPTH];
	logic [7:0] rx_mem [BUF_DEPTH];

	////////////////////////////////////////////////////////////////////////////
	// Serial port slave, mode 0, sampled by clk_i
	logic [2:0] sck_s_q, cs_s_q, mosi_s_q;
	logic       sck_lvl_q, cs_lvl_q;
	logic [2:0] bit_q, bit_d;
	logic [7:0] sh_in_q, sh_in_d, sh_out_q, sh_out_d, idx_q, idx_d, cmd_q, cmd_d;
	logic [7:0] rd_ptr_q, rd_ptr_d, tx_len_q, tx_len_d, st_byte_q, st_byte_d;
	logic [3:0] chan_q, chan_d;
	logic       stream_q, stream_d, st_full_q, st_full_d;
	logic       sck_rise, sck_fall, go, cca_go, stat_rd, tmem_we, st_take;
	logic [7:0] in_b, out_b;
	logic [EV_W-1:0] ev_q, ev_d, ev_set;
	logic [7:0] lqi_q, rx_word_q;
	logic       crc_ok_q, cca_busy_q, tx_busy;

	// A level counts once stages two and three agree
	assign sck_rise = (sck_s_q[1] == sck_s_q[2]) && sck_s_q[2] && !sck_lvl_q;
	assign sck_fall = (sck_s_q[1] == sck_s_q[2]) && !sck_s_q[2] && sck_lvl_q;

	always_comb begin
		bit_d = bit_q;  sh_in_d = sh_in_q;  sh_out_d = sh_out_q;  idx_d = idx_q;
		cmd_d = cmd_q;  rd_ptr_d = rd_ptr_q;  tx_len_d = tx_len_q;  chan_d = chan_q;
		stream_d = stream_q;  st_byte_d = st_byte_q;  st_full_d = st_full_q;
		go = 1'b0;  cca_go = 1'b0;  stat_rd = 1'b0;  tmem_we = 1'b0;
		in_b = {sh_in_q[6:0], mosi_s_q[2]};
		out_b = RST_BYTE;
		if (st_take) st_full_d = 1'b0;
		if (cs_lvl_q) begin
			bit_d = 3'h0;
			idx_d = 8'h00;
			sh_out_d = RST_BYTE;
		end else if (sck_rise) begin
			sh_in_d = in_b;
			bit_d = bit_q + 3'h1;
			if (bit_q == 3'h7) begin
				if (idx_q != 8'hFF) idx_d = idx_q + 8'h01;
				if (idx_q == 8'h00) begin
					cmd_d = in_b;
					rd_ptr_d = 8'h00;
					go = (in_b == CMD_TXGO);
				end else begin
					case (cmd_q)
						CMD_TXWR: begin
							if (idx_q == 8'h01) tx_len_d = in_b;
							tmem_we = (idx_q >= 8'h02) && (idx_q < 8'(BUF_DEPTH + 2));
						end
						CMD_CFG: if (idx_q == 8'h01) begin
							stream_d = in_b[CFG_STREAM];
							chan_d = in_b[CHAN_W-1:0];
							cca_go = in_b[CFG_CCA];
						end
						CMD_STWR: if (idx_q == 8'h01) begin
							st_byte_d = in_b;
							st_full_d = 1'b1;
						end
						default: ;
					endcase
				end
				case ((idx_q == 8'h00) ? in_b : cmd_q)
					CMD_STAT: begin
						if (idx_q == 8'h00) begin
							out_b = {tx_busy, cca_busy_q, crc_ok_q, ev_q};
							stat_rd = 1'b1;
						end else begin
							out_b = lqi_q;
						end
					end
					CMD_RXRD: begin
						out_b = rx_mem[rd_ptr_d[ADDR_W-1:0]];
						rd_ptr_d = rd_ptr_d + 8'h01;
					end
					CMD_STRD: out_b = rx_word_q;
					default: ;
				endcase
				sh_out_d = out_b;
			end
		end else if (sck_fall && bit_q != 3'h0) begin
			// No shift on the fall after a byte: the new byte just loaded
			sh_out_d = {sh_out_q[6:0], 1'b0};
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			sck_s_q <= 3'h0;  cs_s_q <= 3'h7;  mosi_s_q <= 3'h0;
			sck_lvl_q <= 1'b0;  cs_lvl_q <= 1'b1;  bit_q <= 3'h0;
			sh_in_q <= RST_BYTE;  sh_out_q <= RST_BYTE;  idx_q <= RST_BYTE;
			cmd_q <= RST_BYTE;  rd_ptr_q <= RST_BYTE;  tx_len_q <= RST_BYTE;
			chan_q <= RST_CHAN;  stream_q <= 1'b0;  st_byte_q <= RST_BYTE;
			st_full_q <= 1'b0;
		end else begin
			sck_s_q <= {sck_s_q[1:0], spi_sck_i};
			cs_s_q <= {cs_s_q[1:0], spi_cs_n_i};
			mosi_s_q <= {mosi_s_q[1:0], spi_mosi_i};
			if (sck_s_q[1] == sck_s_q[2]) sck_lvl_q <= sck_s_q[2];
			if (cs_s_q[1] == cs_s_q[2]) cs_lvl_q <= cs_s_q[2];
			bit_q <= bit_d;  sh_in_q <= sh_in_d;  sh_out_q <= sh_out_d;  idx_q <= idx_d;
			cmd_q <= cmd_d;  rd_ptr_q <= rd_ptr_d;  tx_len_q <= tx_len_d;
			chan_q <= chan_d;  stream_q <= stream_d;  st_byte_q <= st_byte_d;
			st_full_q <= st_full_d;
		end
		if (tmem_we) tx_mem[ADDR_W'(idx_q - 8'h02)] <= in_b;
	end

	assign spi_miso_o    = sh_out_q[7];
	assign spi_miso_oe_o = !cs_lvl_q;
	assign chan_o        = chan_q;

	////////////////////////////////////////////////////////////////////////////
	// Transmit framer
	psf_tx_e    tx_q, tx_d;
	logic [7:0] tx_data_q, tx_data_d, pidx_q, pidx_d;
	logic [1:0] pre_q, pre_d;
	logic       acc, go_ok, req_set;

	assign acc     = tx_valid_o && tx_ready_i;
	assign tx_busy = (tx_q != T_IDLE);
	assign go_ok   = go && !tx_busy && (tx_len_q <= 8'(MAX_PAY));

	always_comb begin
		tx_d = tx_q;  tx_data_d = tx_data_q;  pidx_d = pidx_q;  pre_d = pre_q;
		st_take = 1'b0;  req_set = 1'b0;
		txc.clr = 1'b0;  txc.en = 1'b0;  txc.data = tx_mem[pidx_q[ADDR_W-1:0]];
		case (tx_q)
			T_IDLE: if (go_ok) begin
				tx_d = T_PRE;  tx_data_d = PRE_VAL;  pre_d = 2'h0;  pidx_d = 8'h00;
				txc.clr = 1'b1;
				req_set = stream_q && (tx_len_q != 8'h00);
			end
			T_PRE: if (acc) begin
				pre_d = pre_q + 2'h1;
				if (pre_q == 2'(PRE_BYTES - 1)) begin
					tx_d = T_SFD;  tx_data_d = SFD_VAL;
				end
			end
			T_SFD: if (acc) begin
				tx_d = T_LEN;  tx_data_d = tx_len_q + 8'(FCS_BYTES);
			end
			T_LEN: if (acc) tx_d = (tx_len_q == 8'h00) ? T_PAY : T_FETCH;
			T_FETCH: begin
				if (stream_q) txc.data = st_byte_q;
				if (!stream_q || st_full_q) begin
					tx_d = T_PAY;  tx_data_d = txc.data;  txc.en = 1'b1;
					pidx_d = pidx_q + 8'h01;
					st_take = stream_q;
					req_set = stream_q && (pidx_d != tx_len_q);
				end
			end
			T_PAY: if (acc || tx_len_q == 8'h00) begin
				// Empty payload passes straight to the check bytes
				tx_d = (pidx_q == tx_len_q) ? T_FCS0 : T_FETCH;
				tx_data_d = txc.crc[7:0];
			end
			T_FCS0: if (acc) begin
				tx_d = T_FCS1;  tx_data_d = txc.crc[15:8];
			end
			T_FCS1: if (acc) tx_d = T_IDLE;
			default: tx_d = T_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			tx_q <= T_IDLE;  tx_data_q <= RST_BYTE;  pidx_q <= RST_BYTE;  pre_q <= 2'h0;
		end else begin
			tx_q <= tx_d;  tx_data_q <= tx_data_d;  pidx_q <= pidx_d;  pre_q <= pre_d;
		end
	end

	assign tx_valid_o = tx_q inside {T_PRE, T_SFD, T_LEN, T_FCS0, T_FCS1}
		|| (tx_q == T_PAY && tx_len_q != 8'h00);
	assign tx_data_o = tx_data_q;

	////////////////////////////////////////////////////////////////////////////
	// Receive parser
	psf_rx_e    rx_q, rx_d;
	logic [2:0] z_q, z_d;
	logic [7:0] rcnt_q, rcnt_d, ridx_q, ridx_d, rx_word_d;
	logic       crc_ok_d, rmem_we, sfd_hit;

	always_comb begin
		rx_d = rx_q;  z_d = z_q;  rcnt_d = rcnt_q;  ridx_d = ridx_q;
		rx_word_d = rx_word_q;  crc_ok_d = crc_ok_q;  rmem_we = 1'b0;  sfd_hit = 1'b0;
		rxc.clr = 1'b0;  rxc.en = 1'b0;  rxc.data = rx_data_i;
		case (rx_q)
			R_HUNT: if (rx_valid_i) begin
				if (rx_data_i == PRE_VAL) begin
					if (z_q != 3'(PRE_BYTES)) z_d = z_q + 3'h1;
				end else begin
					z_d = 3'h0;
					if (rx_data_i == SFD_VAL && z_q == 3'(PRE_BYTES)) begin
						// An accepted length byte lands at the buffer head, whatever the last frame left
						rx_d = R_LEN;  sfd_hit = 1'b1;  ridx_d = 8'h00;
					end
				end
			end
			R_LEN: if (rx_valid_i) begin
				if (rx_data_i < 8'(MIN_FLI) || rx_data_i > 8'(MAX_FLI)) begin
					rx_d = R_HUNT;
				end else begin
					rx_d = R_DATA;  rcnt_d = rx_data_i;  ridx_d = 8'h01;
					rmem_we = 1'b1;  rxc.clr = 1'b1;
				end
			end
			R_DATA: if (rx_valid_i) begin
				rmem_we = 1'b1;  rxc.en = 1'b1;  rx_word_d = rx_data_i;
				ridx_d = ridx_q + 8'h01;  rcnt_d = rcnt_q - 8'h01;
				if (rcnt_q == 8'h01) rx_d = R_CHK;
			end
			R_CHK: begin
				crc_ok_d = (rxc.crc == CRC_GOOD);
				rx_d = R_HUNT;
			end
			default: rx_d = R_HUNT;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			rx_q <= R_HUNT;  z_q <= 3'h0;  rcnt_q <= RST_BYTE;  ridx_q <= RST_BYTE;
			rx_word_q <= RST_BYTE;  crc_ok_q <= 1'b0;
		end else begin
			rx_q <= rx_d;  z_q <= z_d;  rcnt_q <= rcnt_d;  ridx_q <= ridx_d;
			rx_word_q <= rx_word_d;  crc_ok_q <= crc_ok_d;
		end
		if (rmem_we) rx_mem[ridx_q[ADDR_W-1:0]] <= rx_data_i;
	end

	////////////////////////////////////////////////////////////////////////////
	// Link quality, channel assessment and events
	logic [CNT_W-1:0] lqi_cnt_q, lqi_cnt_d, cca_cnt_q, cca_cnt_d;
	logic [7:0]       lqi_max_q, lqi_max_d, lqi_d;
	logic [ACC_W-1:0] cca_acc_q, cca_acc_d;
	logic             cca_busy_d;

	always_comb begin
		lqi_cnt_d = lqi_cnt_q;  lqi_max_d = lqi_max_q;  lqi_d = lqi_q;
		cca_cnt_d = cca_cnt_q;  cca_acc_d = cca_acc_q;  cca_busy_d = cca_busy_q;
		ev_set = '0;
		// Peak energy in the window stands for link quality
		if (sfd_hit) begin
			lqi_cnt_d = CNT_W'(LQI_CYC);  lqi_max_d = RST_BYTE;
		end else if (lqi_cnt_q != '0) begin
			lqi_cnt_d = lqi_cnt_q - 1'b1;
			if (rx_energy_i > lqi_max_q) lqi_max_d = rx_energy_i;
			if (lqi_cnt_q == CNT_W'(1)) lqi_d = lqi_max_d;
		end
		if (cca_go && cca_cnt_q == '0) begin
			cca_cnt_d = CNT_W'(CCA_CYC);  cca_acc_d = '0;
		end else if (cca_cnt_q != '0) begin
			cca_cnt_d = cca_cnt_q - 1'b1;
			cca_acc_d = cca_acc_q + ACC_W'(rx_energy_i);
			if (cca_cnt_q == CNT_W'(1)) begin
				cca_busy_d = (cca_acc_d > CCA_LIM);
				ev_set[ST_CCA] = 1'b1;
			end
		end
		ev_set[ST_TXDONE] = (tx_q == T_FCS1) && acc && !stream_q;
		ev_set[ST_RXDONE] = (rx_q == R_CHK) && !stream_q;
		ev_set[ST_RXWORD] = (rx_q == R_DATA) && rx_valid_i && stream_q;
		ev_set[ST_TXREQ]  = req_set;
		// Set wins over the clear done by the status read
		ev_d = (ev_q & ~({EV_W{stat_rd}})) | ev_set;
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			lqi_cnt_q <= '0;  lqi_max_q <= RST_BYTE;  lqi_q <= RST_BYTE;
			cca_cnt_q <= '0;  cca_acc_q <= '0;  cca_busy_q <= 1'b0;  ev_q <= '0;
		end else begin
			lqi_cnt_q <= lqi_cnt_d;  lqi_max_q <= lqi_max_d;  lqi_q <= lqi_d;
			cca_cnt_q <= cca_cnt_d;  cca_acc_q <= cca_acc_d;  cca_busy_q <= cca_busy_d;
			ev_q <= ev_d;
		end
	end

	assign irq_o = |ev_q;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	property p_sfd; (tx_q == T_PRE && acc && pre_q == 2'h3) |=> tx_data_o == SFD_VAL; endproperty
	a_sfd: assert property (p_sfd) else $error("delimiter not after preamble");
	property p_fli; (tx_q == T_SFD && acc) |=> tx_data_o == $past(tx_len_q) + 8'h02; endproperty
	a_fli: assert property (p_fli) else $error("length byte wrong");
	property p_fcs; (tx_q == T_FCS0 && acc) |=> (tx_data_o == txc.crc[15:8]) && tx_q == T_FCS1;
	endproperty
	a_fcs: assert property (p_fcs) else $error("check high byte wrong");
	property p_nogo; (tx_q == T_IDLE && !go) |=> tx_q == T_IDLE && !tx_valid_o; endproperty
	a_nogo: assert property (p_nogo) else $error("sent without command");
	property p_len; tx_busy |-> tx_len_q <= 8'h7D; endproperty
	a_len: assert property (p_len) else $error("payload over limit");
	property p_txdone; (tx_q == T_FCS1 && acc && !stream_q) |=> ev_q[ST_TXDONE] && irq_o;
	endproperty
	a_txdone: assert property (p_txdone) else $error("no sent interrupt");
	property p_txreq; (go_ok && stream_q && tx_len_q != 8'h00) |=> ev_q[ST_TXREQ] && irq_o;
	endproperty
	a_txreq: assert property (p_txreq) else $error("no ready interrupt");
	property p_rxdone; (rx_q == R_CHK && !stream_q) |=> ev_q[ST_RXDONE] && rx_q == R_HUNT;
	endproperty
	a_rxdone: assert property (p_rxdone) else $error("no frame interrupt");
	property p_crc; (rx_q == R_CHK) |=> crc_ok_q == ($past(rxc.crc) == 16'h0000); endproperty
	a_crc: assert property (p_crc) else $error("check result wrong");
	property p_word; (!stream_q && !$past(stream_q)) |-> !$rose(ev_q[ST_RXWORD]); endproperty
	a_word: assert property (p_word) else $error("byte interrupt in packet mode");

endmodule

`default_nettype wire

// ---- rtl/psf_pkg.sv ----
package psf_pkg;

	// Frame layout
	localparam int          PRE_BYTES = 4;
	localparam logic [7:0]  PRE_VAL   = 8'h00;
	localparam logic [7:0]  SFD_VAL   = 8'hA7;
	localparam int          MAX_PAY   = 125;
	localparam int          FCS_BYTES = 2;
	localparam int          MIN_FLI   = FCS_BYTES;
	localparam int          MAX_FLI   = MAX_PAY + FCS_BYTES;
	localparam int          BUF_DEPTH = 128;
	localparam int          ADDR_W    = 7;

	// Check sequence: reflected x^16+x^12+x^5+1
	localparam logic [15:0] CRC_POLY  = 16'h8408;
	localparam logic [15:0] CRC_INIT  = 16'h0000;
	localparam logic [15:0] CRC_GOOD  = 16'h0000;

	// Timing
	localparam int          CLK_MHZ   = 100;
	localparam int          LQI_US    = 64;
	localparam int          LQI_CYC   = LQI_US * CLK_MHZ;
	localparam int          CCA_US    = 128;
	localparam int          CCA_CYC   = CCA_US * CLK_MHZ;
	localparam int          CCA_THR   = 64;
	localparam int          CNT_W     = 16;
	localparam int          ACC_W     = 24;

	// Serial port commands
	localparam logic [7:0]  CMD_TXWR  = 8'h01;
	localparam logic [7:0]  CMD_TXGO  = 8'h02;
	localparam logic [7:0]  CMD_RXRD  = 8'h03;
	localparam logic [7:0]  CMD_CFG   = 8'h04;
	localparam logic [7:0]  CMD_STAT  = 8'h05;
	localparam logic [7:0]  CMD_STWR  = 8'h06;
	localparam logic [7:0]  CMD_STRD  = 8'h07;

	// Configuration byte fields
	localparam int          CFG_STREAM = 7;
	localparam int          CFG_CCA    = 6;
	localparam int          CHAN_W     = 4;

	// Event bits, low five bits of the status byte
	localparam int          EV_W       = 5;
	localparam int          ST_TXDONE  = 0;
	localparam int          ST_RXDONE  = 1;
	localparam int          ST_TXREQ   = 2;
	localparam int          ST_RXWORD  = 3;
	localparam int          ST_CCA     = 4;

	// Reset values
	localparam logic [7:0]  RST_BYTE   = 8'h00;
	localparam logic [3:0]  RST_CHAN   = 4'h0;

endpackage

// ---- tb/psf_framer_test.sv ----
`timescale 1ns/1ns
`default_nettype none

module psf_framer_test;
	localparam int TMO = 40000;

	logic       clk_i;
	logic       rstn_i;
	logic       sck;
	logic       cs_n;
	logic       mosi;
	logic       miso;
	logic       miso_oe;
	logic       miso_w;
	logic       irq;
	logic [7:0] tx_data;
	logic       tx_valid;
	logic       tx_ready_i;
	logic [7:0] rx_data_i;
	logic       rx_valid_i;
	logic [7:0] rx_energy_i;
	logic [3:0] chan;
	int         num_errors;
	int         cmp_count;
	int         cyc;
	logic [7:0] txq[$];
	logic [7:0] exq[$];
	logic [7:0] nil[$];
	logic [7:0] st;
	logic [7:0] lqi;

	// Pull-up holds the data line while the device lets go
	assign miso_w = miso_oe ? miso : 1'b1;

	psf_framer #(.LQI_CYC(16), .CCA_CYC(16), .CCA_THR(64)) DUT (
		.clk_i(clk_i), .rstn_i(rstn_i), .spi_sck_i(sck), .spi_cs_n_i(cs_n),
		.spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(miso_oe), .irq_o(irq),
		.tx_data_o(tx_data), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready_i),
		.rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i), .rx_energy_i(rx_energy_i),
		.chan_o(chan));

	psf_host host (.sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso_w), .irq_i(irq));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// Modem sink stalls every other cycle
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		tx_ready_i <= ~tx_ready_i;
		if (tx_valid && tx_ready_i)
			txq.push_back(tx_data);
		if (cyc == TMO) begin
			num_errors++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("TB: %0d compares, %0d errors", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("[ERR] %s expected %h seen %h", w, e, g);
			num_errors++;
		end
	endtask

	task automatic chk1(input string w, input logic e, input logic g);
		chk(w, {7'h00, e}, {7'h00, g});
	endtask

	function automatic logic [15:0] crc16(input logic [7:0] d[$]);
		logic [15:0] c;
		c = psf_pkg::CRC_INIT;
		foreach (d[k])
			for (int b = 0; b < 8; b++)
				c = (c[0] ^ d[k][b]) ? ((c >> 1) ^ psf_pkg::CRC_POLY) : (c >> 1);
		return c;
	endfunction

	// Whole frame as it appears on the air
	task automatic frm(input logic [7:0] fli, input logic [7:0] p[$], input logic [15:0] c);
		exq = '{psf_pkg::PRE_VAL, psf_pkg::PRE_VAL, psf_pkg::PRE_VAL, psf_pkg::PRE_VAL,
			psf_pkg::SFD_VAL, fli};
		foreach (p[k])
			exq.push_back(p[k]);
		exq.push_back(c[7:0]);
		exq.push_back(c[15:8]);
	endtask

	task automatic cmd(input logic [7:0] c, input logic [7:0] a[$]);
		host.wq = {};
		host.wq.push_back(c);
		foreach (a[k])
			host.wq.push_back(a[k]);
		host.frame();
	endtask

	task automatic status();
		cmd(psf_pkg::CMD_STAT, '{8'h00, 8'h00});
		st  = host.rq[1];
		lqi = host.rq[2];
	endtask

	task automatic tx_wait(input int n);
		for (int w = 0; w < 3000 && txq.size() < n; w++)
			@(posedge clk_i);
		repeat (10) @(posedge clk_i);
	endtask

	task automatic tx_cmp();
		tx_wait(exq.size());
		chk("tx count", 8'(exq.size()), 8'(txq.size()));
		foreach (exq[k])
			chk("tx byte", exq[k], txq[k]);
	endtask

	// Peak pk at the length byte inside the window after the delimiter; higher energy before and after it
	task automatic rx_send(input logic [7:0] q[$], input logic [7:0] pk);
		foreach (q[k]) begin
			@(posedge clk_i);
			rx_data_i   <= q[k];
			rx_valid_i  <= 1'b1;
			rx_energy_i <= (k < 4) ? 8'hF0 : (k == 5) ? pk : (k >= 10) ? 8'hF8 : 8'h10;
			@(posedge clk_i);
			rx_valid_i <= 1'b0;
			rx_data_i  <= ~q[k];
			repeat (2) @(posedge clk_i);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////

	task automatic t_pkt_tx();
		logic [7:0] p[$];
		p = '{8'h11, 8'hC3, 8'h5A};
		cmd(psf_pkg::CMD_CFG, '{8'h05});
		chk("chan", 8'h05, {4'h0, chan});
		txq = {};
		cmd(psf_pkg::CMD_TXWR, '{8'h03, p[0], p[1], p[2]});
		repeat (20) @(posedge clk_i);
		chk("tx early", 8'h00, 8'(txq.size()));
		cmd(psf_pkg::CMD_TXGO, nil);
		frm(8'h05, p, crc16(p));
		tx_cmp();
		chk1("done irq", 1'b1, irq);
		status();
		chk1("done ev", 1'b1, st[psf_pkg::ST_TXDONE]);
		chk1("irq clear", 1'b0, irq);
		$display("TB: packet transmit finished");
	endtask

	// Full-size payload loaded, so no byte of the frame is left undefined
	task automatic t_limit();
		logic [7:0] p[$];
		for (int k = 0; k < 125; k++)
			p.push_back(8'(k));
		txq = {};
		cmd(psf_pkg::CMD_TXWR, {8'h7D, p});
		cmd(psf_pkg::CMD_TXGO, nil);
		frm(8'h7F, p, crc16(p));
		tx_cmp();
		chk("max count", 8'h85, 8'(txq.size()));
		chk("max length", 8'h7F, txq[5]);
		status();
		txq = {};
		cmd(psf_pkg::CMD_TXWR, '{8'h7E});
		cmd(psf_pkg::CMD_TXGO, nil);
		repeat (100) @(posedge clk_i);
		chk("long refused", 8'h00, 8'(txq.size()));
		cmd(8'h3F, '{8'h00});
		chk("unknown", 8'h00, host.rq[1]);
		$display("TB: length limit finished");
	endtask

	task automatic t_pkt_rx(input logic bad);
		logic [7:0] p[$];
		logic [7:0] z[$];
		logic [15:0] c;
		p = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h9A, 8'hBC, 8'hDE, 8'hF0};
		c = crc16(p) ^ {15'h0000, bad};
		frm(8'h0A, p, c);
		rx_send(exq[0:14], 8'h9E);
		repeat (4) @(posedge clk_i);
		chk1("early irq", 1'b0, irq);
		rx_send('{exq[15]}, 8'h10);
		repeat (4) @(posedge clk_i);
		chk1("rx irq", 1'b1, irq);
		status();
		chk1("rx done", 1'b1, st[psf_pkg::ST_RXDONE]);
		chk1("crc ok", ~bad, st[5]);
		chk("lqi", 8'h9E, lqi);
		z = {};
		repeat (11) z.push_back(8'h00);
		cmd(psf_pkg::CMD_RXRD, z);
		for (int k = 0; k < 11; k++)
			chk("rx buf", exq[k + 5], host.rq[k + 1]);
		$display("TB: packet receive finished");
	endtask

	task automatic t_str_tx();
		logic [7:0] p[$];
		logic ok;
		p = '{8'hC0, 8'h3F};
		cmd(psf_pkg::CMD_CFG, '{8'h83});
		chk("chan", 8'h03, {4'h0, chan});
		txq = {};
		cmd(psf_pkg::CMD_TXWR, '{8'h02});
		cmd(psf_pkg::CMD_TXGO, nil);
		foreach (p[k]) begin
			host.wait_irq(20000, ok);
			chk1("req irq", 1'b1, ok);
			status();
			chk1("req ev", 1'b1, st[psf_pkg::ST_TXREQ]);
			cmd(psf_pkg::CMD_STWR, '{p[k]});
		end
		frm(8'h04, p, crc16(p));
		tx_cmp();
		status();
		chk1("no req", 1'b0, st[psf_pkg::ST_TXREQ]);
		chk1("no done", 1'b0, st[psf_pkg::ST_TXDONE]);
		$display("TB: stream transmit finished");
	endtask

	task automatic t_str_rx();
		logic [7:0] p[$];
		p = '{8'h5E, 8'h77};
		frm(8'h04, p, crc16(p));
		status();
		rx_send(exq[0:5], 8'h10);
		for (int k = 6; k < 10; k++) begin
			rx_send('{exq[k]}, 8'h10);
			repeat (4) @(posedge clk_i);
			chk1("word irq", 1'b1, irq);
			cmd(psf_pkg::CMD_STRD, '{8'h00});
			chk("word", exq[k], host.rq[1]);
			status();
			chk1("word ev", 1'b1, st[psf_pkg::ST_RXWORD]);
		end
		$display("TB: stream receive finished");
	endtask

	// Energy at the threshold is clear, one step above is busy
	task automatic t_cca();
		for (int k = 0; k < 2; k++) begin
			@(posedge clk_i);
			rx_energy_i <= 8'h40 + 8'(k);
			cmd(psf_pkg::CMD_CFG, '{8'h40});
			repeat (10) @(posedge clk_i);
			status();
			chk1("cca ev", 1'b1, st[psf_pkg::ST_CCA]);
			chk1("cca busy", k[0], st[6]);
		end
		$display("TB: channel assessment finished");
	endtask

	initial begin
		rstn_i      = 1'b0;
		tx_ready_i  = 1'b0;
		rx_data_i   = 8'h00;
		rx_valid_i  = 1'b0;
		rx_energy_i = 8'h10;
		num_errors  = 0;
		cmp_count   = 0;
		cyc         = 0;
		nil         = {};
		repeat (8) @(posedge clk_i);
		rstn_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		chk1("reset irq", 1'b0, irq);
		chk1("reset valid", 1'b0, tx_valid);
		chk1("reset miso oe", 1'b0, miso_oe);
		chk("reset chan", 8'h00, {4'h0, chan});
		t_pkt_tx();
		t_limit();
		t_pkt_rx(1'b0);
		t_pkt_rx(1'b1);
		t_str_tx();
		t_str_rx();
		t_cca();
		end_of_test();
	end
endmodule

`default_nettype wire

// ---- tb/psf_host.sv ----
`timescale 1ns/1ns
`default_nettype none

module psf_host (
	// Serial port to the device
	output logic      sck_o,
	output logic      cs_n_o,
	output logic      mosi_o,
	input  wire logic miso_i,
	// Interrupt from the device
	input  wire logic irq_i
);
	logic [7:0] wq[$];
	logic [7:0] rq[$];

	initial begin
		sck_o  = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end

	// Mode 0 at 8 MHz; clock rests low between frames
	task automatic frame();
		logic [7:0] r;
		rq = {};
		// Non-blocking, so a pin change on a clock edge cannot race the input flops
		#7 cs_n_o <= 1'b0;
		foreach (wq[k]) begin
			for (int b = 7; b >= 0; b--) begin
				mosi_o <= wq[k][b];
				#62 sck_o <= 1'b1;
				r[b] = miso_i;
				#63 sck_o <= 1'b0;
			end
			rq.push_back(r);
		end
		#63 cs_n_o <= 1'b1;
		// Released line must not keep its last level
		mosi_o <= ~mosi_o;
		#250;
	endtask

	// One word per ready interrupt, wait bounded
	task automatic wait_irq(input int lim, output logic ok);
		for (int n = 0; n < lim && irq_i !== 1'b1; n++)
			#10;
		ok = irq_i;
	endtask
endmodule

`default_nettype wire
